// ---- design/cbsc_top.sv ----
// Purpose: per-socket card clock, clock-run and card reset control
// Assumes: bus clock and clock-run arrive as pins; reset requests come from flops on clk
// Notes: card clock is rebuilt from the sampled bus clock, so it lags it by a few cycles
`timescale 1ns/1ns
`default_nettype none
`include "cbsc_defs.svh"

module cbsc_socket (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic pci_clk_s, // sampled bus clock
  input wire logic pci_clkrun_n_s, // sampled bus clock-run, low = run
  input wire logic stop_en, // power save: 1 stop, 0 slow
  input wire logic reset_req, // card reset request, from a flop
  input wire logic clkrun_in, // clock-run pin level
  input wire logic [`CBSC_CAD_W-1:0] cad_in, // address/data pin levels
  output logic card_clock_reg, // card clock pin
  output logic clkrun_out_reg, // clock-run drive value
  output logic clkrun_oe_reg, // clock-run drive enable
  output logic rst_out_n_reg, // card reset, low = reset
  output logic rst_oe_reg, // card reset drive enable
  output logic [`CBSC_CAD_W-1:0] cad_out_reg, // address/data park value
  output logic [`CBSC_CAD_W-1:0] cad_oe_reg, // address/data park enable
  output logic [`CBSC_CAD_W-1:0] cad_capt_reg // word sampled on card clock rise
);

  // ------------------------------------------------------------
  // pin sampling
  // ------------------------------------------------------------
  logic clkrun_s;
  logic [`CBSC_CAD_W-1:0] cad_s;

  cbsc_sync #(.W(1), .INIT(1'b1)) u_sync_run (
    .clk(clk), .rst_n(rst_n), .d(clkrun_in), .q(clkrun_s)
  );

  cbsc_sync #(.W(`CBSC_CAD_W), .INIT(`CBSC_CAD_PARK)) u_sync_cad (
    .clk(clk), .rst_n(rst_n), .d(cad_in), .q(cad_s)
  );

  // ------------------------------------------------------------
  // clock mode
  // ------------------------------------------------------------
  cbsc_pkg::cbsc_clk_mode_t mode_reg;
  cbsc_pkg::cbsc_clk_mode_t mode_next;
  logic pci_clk_d_reg;
  logic pci_rise;
  logic [`CBSC_SLOW_W-1:0] slow_cnt_reg;
  logic card_clock_next;
  logic card_rise;

  assign pci_rise = pci_clk_s & ~pci_clk_d_reg;

  always_comb
  begin
    // reset in progress keeps the clock running so release can align
    if (!rst_out_n_reg || !pci_clkrun_n_s || !clkrun_s)
      mode_next = cbsc_pkg::CM_RUN;
    else if (stop_en)
      mode_next = cbsc_pkg::CM_STOP;
    else
      mode_next = cbsc_pkg::CM_SLOW;
  end

  // mode only changes while the card clock is low, avoiding runt pulses
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_reg <= cbsc_pkg::CM_RUN;
    else if (!card_clock_reg)
      mode_reg <= mode_next;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pci_clk_d_reg <= 1'b0;
    else
      pci_clk_d_reg <= pci_clk_s;
  end

  // ------------------------------------------------------------
  // card clock generation
  // ------------------------------------------------------------
  always_comb
  begin
    card_clock_next = card_clock_reg;
    case (mode_reg)
      cbsc_pkg::CM_RUN: card_clock_next = pci_clk_s;
      cbsc_pkg::CM_SLOW:
      begin
        if (pci_rise && slow_cnt_reg == `CBSC_SLOW_DIV - 8'h01)
          card_clock_next = ~card_clock_reg;
      end
      cbsc_pkg::CM_STOP: card_clock_next = 1'b0;
      default: card_clock_next = 1'b0;
    endcase
  end

  assign card_rise = card_clock_next & ~card_clock_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      card_clock_reg <= 1'b0;
    else
      card_clock_reg <= card_clock_next;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      slow_cnt_reg <= 8'h00;
    else if (mode_reg != cbsc_pkg::CM_SLOW)
      slow_cnt_reg <= 8'h00;
    else if (pci_rise)
    begin
      if (slow_cnt_reg == `CBSC_SLOW_DIV - 8'h01)
        slow_cnt_reg <= 8'h00;
      else
        slow_cnt_reg <= slow_cnt_reg + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // clock-run line
  // ------------------------------------------------------------
  // open-drain style: bridge pulls low while the bus clock-run asks for run;
  // released line tells the card the clock may be lowered
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clkrun_out_reg <= 1'b0;
      clkrun_oe_reg <= 1'b0;
    end
    else
    begin
      clkrun_out_reg <= 1'b0;
      clkrun_oe_reg <= ~pci_clkrun_n_s;
    end
  end

  // ------------------------------------------------------------
  // card reset and parking
  // ------------------------------------------------------------
  logic arst_n;

  // reset_req must come from a flop so the combined reset cannot glitch
  assign arst_n = rst_n & ~reset_req;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_out_n_reg <= 1'b0;
      cad_oe_reg <= `CBSC_CAD_OE_ALL;
    end
    else if (card_rise)
    begin
      rst_out_n_reg <= 1'b1;
      cad_oe_reg <= `CBSC_CAD_OE_OFF;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_oe_reg <= 1'b0;
      cad_out_reg <= `CBSC_CAD_PARK;
    end
    else
    begin
      rst_oe_reg <= 1'b1;
      cad_out_reg <= `CBSC_CAD_PARK;
    end
  end

  // ------------------------------------------------------------
  // card bus sampling
  // ------------------------------------------------------------
  // bit order kept as on the pins, bit 31 most significant
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cad_capt_reg <= `CBSC_CAD_PARK;
    else if (card_rise)
      cad_capt_reg <= cad_s;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_run_follow;
    @(posedge clk) disable iff (!rst_n)
      (mode_reg == cbsc_pkg::CM_RUN && $past(mode_reg) == cbsc_pkg::CM_RUN)
      |-> card_clock_reg == $past(pci_clk_s);
  endproperty
  a_run_follow: assert property (p_run_follow) else $error("card clock not following bus clock");
  property p_stop_low;
    @(posedge clk) disable iff (!rst_n)
      (mode_reg == cbsc_pkg::CM_STOP && $past(mode_reg) == cbsc_pkg::CM_STOP)
      |-> !card_clock_reg;
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("stopped card clock not low");
  property p_lowered;
    @(posedge clk) disable iff (!rst_n)
      ($changed(mode_reg) && mode_reg != cbsc_pkg::CM_RUN) |-> !clkrun_oe_reg;
  endproperty
  a_lowered: assert property (p_lowered) else $error("clock lowered with clock-run held");
  property p_clkrun_track;
    @(posedge clk) disable iff (!rst_n)
      $changed(pci_clkrun_n_s) |=> clkrun_oe_reg == !$past(pci_clkrun_n_s);
  endproperty
  a_clkrun_track: assert property (p_clkrun_track) else $error("clock-run not tracking");
  property p_park;
    @(posedge clk) disable iff (!rst_n)
      !rst_out_n_reg |-> (cad_oe_reg == `CBSC_CAD_OE_ALL && cad_out_reg == `CBSC_CAD_PARK);
  endproperty
  a_park: assert property (p_park) else $error("card bus not parked in reset");
  property p_async_assert;
    @(posedge clk) disable iff (!rst_n)
      reset_req |-> !rst_out_n_reg;
  endproperty
  a_async_assert: assert property (p_async_assert) else $error("card reset not asserted");
  property p_sync_release;
    @(posedge clk) disable iff (!rst_n)
      $rose(rst_out_n_reg) |-> (card_clock_reg && !$past(card_clock_reg));
  endproperty
  a_sync_release: assert property (p_sync_release) else $error("reset release unaligned");
  property p_capture;
    @(posedge clk) disable iff (!rst_n)
      $past(card_rise) |-> cad_capt_reg == $past(cad_s);
  endproperty
  a_capture: assert property (p_capture) else $error("bus word not sampled on rise");

endmodule

module cbsc_top (
  input wire logic clk, // system clock, 50 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic pci_clk, // bus clock pin
  input wire logic pci_clkrun_n, // bus clock-run pin, low = run
  input wire logic [1:0] power_stop_en, // per socket: 1 stop, 0 slow
  input wire logic [1:0] card_reset_req, // per socket reset request
  input wire logic [1:0] card_clock_run_line_in, // clock-run pin levels
  input wire logic [1:0][`CBSC_CAD_W-1:0] card_addr_data_bus_in, // bus pin levels
  output logic [1:0] card_clock, // card clock pins
  output logic [1:0] card_clock_run_line_out, // clock-run drive value
  output logic [1:0] card_clock_run_line_oe, // clock-run drive enable
  output logic [1:0] card_reset_line_n_out, // card reset, low = reset
  output logic [1:0] card_reset_line_oe, // card reset drive enable
  output logic [1:0][`CBSC_CAD_W-1:0] card_addr_data_bus_out, // park value
  output logic [1:0][`CBSC_CAD_W-1:0] card_addr_data_bus_oe, // park enable
  output logic [1:0][`CBSC_CAD_W-1:0] card_bus_sampled // sampled bus word
);

  logic [1:0] pci_s;

  cbsc_sync #(.W(2), .INIT(2'h2)) u_sync_pci (
    .clk(clk), .rst_n(rst_n), .d({pci_clkrun_n, pci_clk}), .q(pci_s)
  );

  // one independent controller per socket
  for (genvar g = 0; g < `CBSC_SOCKETS; g++)
  begin : g_sock
    cbsc_socket u_sock (
      .clk(clk), .rst_n(rst_n), .pci_clk_s(pci_s[0]), .pci_clkrun_n_s(pci_s[1]),
      .stop_en(power_stop_en[g]), .reset_req(card_reset_req[g]),
      .clkrun_in(card_clock_run_line_in[g]), .cad_in(card_addr_data_bus_in[g]),
      .card_clock_reg(card_clock[g]), .clkrun_out_reg(card_clock_run_line_out[g]),
      .clkrun_oe_reg(card_clock_run_line_oe[g]), .rst_out_n_reg(card_reset_line_n_out[g]),
      .rst_oe_reg(card_reset_line_oe[g]), .cad_out_reg(card_addr_data_bus_out[g]),
      .cad_oe_reg(card_addr_data_bus_oe[g]), .cad_capt_reg(card_bus_sampled[g])
    );
  end

endmodule

`default_nettype wire

// ---- inc/cbsc_defs.svh ----
// Purpose: constants for the card socket clock and reset control
// Assumes: one system clock of 50 MHz; card clock made from the sampled bus clock
// Notes: definitions only
`ifndef CBSC_DEFS_SVH
`define CBSC_DEFS_SVH

// ------------------------------------------------------------
// widths and counts
// ------------------------------------------------------------
`define CBSC_SOCKETS 2
`define CBSC_CAD_W 32
`define CBSC_SLOW_DIV 8'h04
`define CBSC_SLOW_W 8

// ------------------------------------------------------------
// reset and park values
// ------------------------------------------------------------
`define CBSC_CAD_PARK 32'h00000000
`define CBSC_CAD_OE_ALL 32'hffffffff
`define CBSC_CAD_OE_OFF 32'h00000000

`endif

// ---- inc/cbsc_pkg.sv ----
// Purpose: types for the card socket clock and reset control
// Assumes: nothing
// Notes: imported by no file; use cbsc_pkg::name
package cbsc_pkg;

  typedef enum logic [1:0] {
    CM_RUN,
    CM_SLOW,
    CM_STOP
  } cbsc_clk_mode_t;

endpackage

// ---- design/cbsc_sync.sv ----
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs arrive from outside the clk domain
// Notes: first stage is read by the second stage only
`timescale 1ns/1ns
`default_nettype none

module cbsc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] d, // raw pin value
  output logic [W-1:0] q // filtered value
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a bit only changes once stages two and three agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= INIT;
    else
    begin
      for (int i = 0; i < W; i++)
      begin
        if (s2_reg[i] == s3_reg[i])
          q[i] <= s3_reg[i];
      end
    end
  end

endmodule

`default_nettype wire

// ---- verif/cbsc_card_model.sv ----
// Purpose: behavioural card sitting in one socket
// Assumes: card clock and card reset as seen at the socket pins
// Notes: a released bus shows all ones, the inverse of the word cleared by reset, not a held value
`timescale 1ns/1ns
`default_nettype none

module cbsc_card_model (
  input wire logic card_clock, // card clock pin
  input wire logic card_reset_n, // card reset line, low = reset
  input wire logic want_fast, // bench asks for a faster clock
  input wire logic [31:0] word, // word to put on the bus
  output logic clkrun_pull, // pulls the clock-run line low
  output logic [31:0] cad_val // bus level from the card side
);
  logic [31:0] last_reg;
  logic drive_reg;

  // silent while in reset, so a held request cannot mask the release
  assign clkrun_pull = want_fast & card_reset_n;
  assign cad_val = drive_reg ? last_reg : ~last_reg;

  always_ff @(posedge card_clock or negedge card_reset_n)
  begin
    if (!card_reset_n)
    begin
      drive_reg <= 1'b0;
      last_reg <= 32'h0;
    end
    else
    begin
      drive_reg <= 1'b1;
      last_reg <= word;
    end
  end
endmodule
`default_nettype wire

// ---- verif/test_cardbus_socket_clock_reset.sv ----
// Purpose: self-checking bench for the socket clock and reset control
// Assumes: bus clock 160 ns, system clock 20 ns
// Notes: each socket faces its own behavioural card
`timescale 1ns/1ns
`default_nettype none

module test_cardbus_socket_clock_reset;
  logic clk, rst_n, pci_clk, pci_clkrun_n;
  logic [1:0] stop_en, reset_req, want_fast, card_clock, cr_out, cr_oe;
  logic [1:0] card_rst_n, card_rst_oe;
  wire [1:0] clkrun_in, pull, card_rst_line;
  logic [1:0][31:0] cad_out, cad_oe, sampled, word;
  wire [1:0][31:0] cad_in, cad_val;
  int mismatches, samples_checked;

  cbsc_top i_cbsc_top (
    .clk(clk), .rst_n(rst_n), .pci_clk(pci_clk), .pci_clkrun_n(pci_clkrun_n),
    .power_stop_en(stop_en), .card_reset_req(reset_req),
    .card_clock_run_line_in(clkrun_in), .card_addr_data_bus_in(cad_in),
    .card_clock(card_clock), .card_clock_run_line_out(cr_out),
    .card_clock_run_line_oe(cr_oe), .card_reset_line_n_out(card_rst_n),
    .card_reset_line_oe(card_rst_oe), .card_addr_data_bus_out(cad_out),
    .card_addr_data_bus_oe(cad_oe), .card_bus_sampled(sampled)
  );

  // ----------------------------------------
  // wire resolution, clock-run pulled up
  // ----------------------------------------
  for (genvar g = 0; g < 2; g++)
  begin : gen_sock
    assign clkrun_in[g] = ~((cr_oe[g] & ~cr_out[g]) | pull[g]);
    assign card_rst_line[g] = card_rst_oe[g] ? card_rst_n[g] : 1'b0;
    assign cad_in[g] = (cad_oe[g] & cad_out[g]) | (~cad_oe[g] & cad_val[g]);
    cbsc_card_model i_cbsc_card_model (
      .card_clock(card_clock[g]), .card_reset_n(card_rst_line[g]), .want_fast(want_fast[g]),
      .word(word[g]), .clkrun_pull(pull[g]), .cad_val(cad_val[g])
    );
  end

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    pci_clk = 1'b0;
    #7;
    forever #80 pci_clk = ~pci_clk;
  end

  task automatic final_report;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for the next rising card clock; n = cycles spent
  task automatic rise(input int s, output int n);
    logic p;
    n = 0;
    p = card_clock[s];
    while (!(p === 1'b0 && card_clock[s] === 1'b1))
    begin
      p = card_clock[s];
      cyc(1);
      n++;
      if (n > 300)
      begin
        mismatches++;
        final_report;
      end
    end
  endtask

  task automatic period(input int s, input int exp);
    int n;
    rise(s, n);
    rise(s, n);
    chk(32'(n), 32'(exp));
  endtask

  task automatic t_run;
    period(0, 8);
    period(1, 8);
    chk(32'(cr_oe), 32'h3);
    chk(32'(cr_out), 32'h0);
    chk(32'(card_rst_oe), 32'h3);
  endtask

  task automatic t_sample;
    int n;
    word[0] = 32'h80000001;
    word[1] = 32'h7ffffffe;
    repeat (3) rise(0, n);
    chk(sampled[0], 32'h80000001);
    chk(sampled[1], 32'h7ffffffe);
  endtask

  task automatic t_stop;
    int h;
    pci_clkrun_n = 1'b1;
    cyc(30);
    chk(32'(cr_oe), 32'h0);
    h = 0;
    repeat (80)
    begin
      cyc(1);
      h += card_clock[0];
    end
    chk(32'(h), 32'h0);
    period(1, 64);
  endtask

  task automatic t_card_req;
    want_fast[0] = 1'b1;
    cyc(20);
    period(0, 8);
    chk(32'(cr_oe), 32'h0);
    want_fast[0] = 1'b0;
  endtask

  // reset lands while the card clock is stopped, the awkward case for release
  task automatic t_reset;
    logic p;
    int n;
    cyc(20);
    reset_req[0] = 1'b1;
    #1;
    chk(32'(card_rst_n), 32'h2);
    chk(cad_oe[0], 32'hffffffff);
    chk(cad_out[0], 32'h0);
    cyc(5);
    reset_req[0] = 1'b0;
    n = 0;
    p = card_clock[0];
    while (card_rst_n[0] !== 1'b1 && n < 300)
    begin
      p = card_clock[0];
      cyc(1);
      n++;
    end
    if (card_rst_n[0] !== 1'b1)
    begin
      mismatches++;
      final_report;
    end
    chk({30'h0, p, card_clock[0]}, 32'h1);
    chk(cad_oe[0], 32'h0);
  endtask

  initial
  begin
    rst_n = 1'b0;
    pci_clkrun_n = 1'b0;
    stop_en = 2'b01;
    reset_req = '0;
    want_fast = '0;
    word = '0;
    mismatches = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    #2;
    chk({29'h0, card_clock[0], card_rst_n[0], card_rst_oe[0]}, 32'h0);
    chk(cad_oe[1], 32'hffffffff);
    rst_n = 1'b1;
    t_run;
    t_sample;
    t_stop;
    t_card_req;
    t_reset;
    final_report;
  end
endmodule
`default_nettype wire
